// file: hdl/tag_codec_pkg.sv
// Purpose: Shared constants and carriers for the contactless tag frame codec
// Assumes: clk_sys at 125 MHz (8 ns period)
// Notes: Timing counts are derived from the printed times and the clock rate
package tag_codec_pkg;
    localparam int CLK_NS = 8;
    localparam int CLK_KHZ = 125000;

    // One bit period is 9.44 us
    localparam int BIT_NS = 9440;
    localparam logic [15:0] BIT_CYCLES = 16'((BIT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES / 2);

    // Receive tolerance windows, in clock cycles
    localparam logic [15:0] LOW_MIN = 16'((BIT_NS * 19 / 2) / CLK_NS);
    localparam logic [15:0] LOW_MAX = 16'((BIT_NS * 11) / CLK_NS);
    localparam logic [15:0] HIGH_MIN = 16'((BIT_NS * 3 / 2) / CLK_NS);
    localparam logic [15:0] HIGH_MAX = 16'((BIT_NS * 7 / 2) / CLK_NS);
    localparam logic [15:0] GAP_MAX = 16'((BIT_NS * 8) / CLK_NS);
    localparam logic [15:0] EOF_RISE_MAX = 16'((BIT_NS * 3 / 2) / CLK_NS);

    // Subcarrier of 847 kHz
    localparam int SUBC_KHZ = 847;
    localparam logic [7:0] SUBC_HALF_CYCLES = 8'(CLK_KHZ / (2 * SUBC_KHZ));

    // Turnaround guard and sync time, both 128 subcarrier periods
    localparam int TURN_SUBC_PERIODS = 128;
    localparam int GUARD_NS =
        (TURN_SUBC_PERIODS * 1000000 + SUBC_KHZ - 1) / SUBC_KHZ;
    localparam int GUARD_CYCLES = (GUARD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [9:0] SYNC_HALVES = 10'(2 * TURN_SUBC_PERIODS);

    // Character and frame marker layout
    localparam logic [3:0] STOP_BIT_IDX = 4'h9;
    localparam logic [3:0] MARK_ZERO_BITS = 4'ha;
    localparam logic [3:0] MARK_LAST_BIT = 4'hb;

    // CRC with reflected polynomial, preset all ones
    localparam logic [15:0] CRC_PRESET = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;
    localparam logic [3:0] CRC_BYTES = 4'h2;

    // Frame buffer holds at most eight bytes including the CRC
    localparam logic [3:0] MAX_BYTES = 4'h8;

    // Block memory
    localparam int BLOCKS = 64;

    typedef struct packed {
        logic valid;
        logic [3:0] len;
        logic [63:0] data;
    } frame_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic permit;
        logic [5:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } mem_rsp_t;
endpackage

// file: hdl/crc16_unit.sv
// Purpose: Byte-wide CRC register, one byte per cycle, LSB first
// Assumes: init and en never high together
// Notes: Output is the raw register; transmit sends its complement
`timescale 1ns/1ns
module crc16_unit (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic init,
    input wire logic en,
    input wire logic [7:0] din,
    output logic [15:0] crc_r
);
    logic [15:0] stage [0:8];

    assign stage[0] = crc_r;
    for (genvar g = 0; g < 8; g++) begin : g_bit
        assign stage[g + 1] = (stage[g][0] ^ din[g]) ?
            ({1'b0, stage[g][15:1]} ^ tag_codec_pkg::CRC_POLY) :
            {1'b0, stage[g][15:1]};
    end

    always_ff @(posedge clk_sys) begin
        if (srst || init) begin
            crc_r <= tag_codec_pkg::CRC_PRESET;
        end else if (en) begin
            crc_r <= stage[8];
        end
    end
endmodule // crc16_unit

// file: hdl/block_store.sv
// Purpose: Tag memory of 64 blocks of 32 bits
// Assumes: One request per cycle
// Notes: Contents are not cleared by reset, as in non-volatile storage
`timescale 1ns/1ns
module block_store (
    input wire logic clk_sys,
    input wire logic srst,
    input tag_codec_pkg::mem_req_t req,
    output tag_codec_pkg::mem_rsp_t rsp_r
);
    logic [31:0] mem_r [0:tag_codec_pkg::BLOCKS - 1];

    always_ff @(posedge clk_sys) begin
        if (req.valid && req.write && req.permit) begin
            mem_r[req.addr] <= req.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= req.valid && !req.write;
            if (req.valid && !req.write) begin
                rsp_r.rdata <= mem_r[req.addr];
            end
        end
    end
endmodule // block_store

// file: hdl/tag_frame_codec.sv
// Purpose: Frame codec of a contactless tag: request parser, answer builder
// Assumes: rx_demod is the demodulated envelope, low while modulated
// Notes: load_mod drives the load modulation switch across the antenna
`timescale 1ns/1ns
module tag_frame_codec #(
    parameter int unsigned GUARD_CYCLES = tag_codec_pkg::GUARD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic rx_demod,
    output tag_codec_pkg::frame_t rx_frame_r,
    output logic rx_err_r,
    output logic rx_busy,
    input tag_codec_pkg::frame_t tx_req,
    output logic tx_ready,
    output logic tx_busy,
    output logic load_mod_r,
    input tag_codec_pkg::mem_req_t mem_req,
    output tag_codec_pkg::mem_rsp_t mem_rsp
);
    typedef enum logic [2:0] {
        RX_IDLE, RX_SOF_LOW, RX_SOF_HIGH, RX_CHAR, RX_GAP, RX_EOF
    } rx_state_t;
    typedef enum logic [2:0] {
        TX_IDLE, TX_GUARD, TX_SYNC, TX_SOF, TX_CHAR, TX_EOF
    } tx_state_t;

    localparam logic [15:0] GUARD_LIMIT = 16'(GUARD_CYCLES);
    localparam logic [15:0] HALF_BIT = tag_codec_pkg::HALF_BIT;
    localparam logic [3:0] MARK_ZERO_BITS = tag_codec_pkg::MARK_ZERO_BITS;

    rx_state_t rx_st_r;
    tx_state_t tx_st_r;
    logic rx_s1_r;
    logic rx_s2_r;
    logic rx_prev_r;
    logic rx_fall;
    logic rx_rise;
    logic [15:0] rx_tmr_r;
    logic [15:0] rx_samp;
    logic [3:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic [3:0] rx_cnt_r;
    logic [63:0] rx_data_r;
    logic rx_crc_init;
    logic rx_crc_en;
    logic [15:0] rx_crc;
    logic [15:0] guard_cnt_r;
    logic [7:0] subc_cnt_r;
    logic subc_r;
    logic subc_flip;
    logic [9:0] sync_cnt_r;
    logic [15:0] tx_tmr_r;
    logic [3:0] tx_bit_r;
    logic [3:0] tx_idx_r;
    logic [3:0] tx_len_r;
    logic [63:0] tx_data_r;
    logic tx_bit_end;
    logic tx_crc_en;
    logic [15:0] tx_crc;
    logic [7:0] tx_byte;
    logic tx_lvl;
    logic tx_on;

    // Pin synchroniser and edge detection on the settled level
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_s1_r <= rx_demod;
            rx_s2_r <= rx_s1_r;
            rx_prev_r <= rx_s2_r;
        end
    end

    assign rx_fall = rx_prev_r && !rx_s2_r;
    assign rx_rise = !rx_prev_r && rx_s2_r;
    assign rx_busy = (rx_st_r != RX_IDLE);
    // Start bit sampled mid-bit, later bits one bit period apart
    assign rx_samp = (rx_bit_r == 4'h0) ? 16'(HALF_BIT - 16'h0001) :
        16'(tag_codec_pkg::BIT_CYCLES - 16'h0001);
    assign rx_crc_init = (rx_st_r == RX_IDLE) && rx_fall;
    assign rx_crc_en = (rx_st_r == RX_CHAR) && (rx_tmr_r == rx_samp) &&
        (rx_bit_r == tag_codec_pkg::STOP_BIT_IDX) && rx_s2_r &&
        (rx_cnt_r != tag_codec_pkg::MAX_BYTES);

    crc16_unit u_rx_crc (
        .clk_sys(clk_sys),
        .srst(srst),
        .init(rx_crc_init),
        .en(rx_crc_en),
        .din(rx_sh_r),
        .crc_r(rx_crc)
    );

    // Request parser
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_st_r <= RX_IDLE;
            rx_tmr_r <= 16'h0000;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 4'h0;
            rx_data_r <= 64'h0;
            rx_frame_r <= '0;
            rx_err_r <= 1'b0;
        end else begin
            rx_frame_r.valid <= 1'b0;
            rx_err_r <= 1'b0;
            rx_tmr_r <= 16'(rx_tmr_r + 16'h0001);
            unique case (rx_st_r)
                RX_IDLE: begin
                    rx_tmr_r <= 16'h0000;
                    rx_cnt_r <= 4'h0;
                    if (rx_fall) begin
                        rx_st_r <= RX_SOF_LOW;
                    end
                end
                RX_SOF_LOW: begin
                    if (rx_rise) begin
                        rx_tmr_r <= 16'h0000;
                        if (rx_tmr_r >= tag_codec_pkg::LOW_MIN) begin
                            rx_st_r <= RX_SOF_HIGH;
                        end else begin
                            rx_st_r <= RX_IDLE;
                            rx_err_r <= 1'b1;
                        end
                    end else if (rx_tmr_r > tag_codec_pkg::LOW_MAX) begin
                        rx_st_r <= RX_IDLE;
                        rx_err_r <= 1'b1;
                    end
                end
                RX_SOF_HIGH: begin
                    if (rx_fall) begin
                        rx_tmr_r <= 16'h0000;
                        rx_bit_r <= 4'h0;
                        if (rx_tmr_r >= tag_codec_pkg::HIGH_MIN) begin
                            rx_st_r <= RX_CHAR;
                        end else begin
                            rx_st_r <= RX_IDLE;
                            rx_err_r <= 1'b1;
                        end
                    end else if (rx_tmr_r > tag_codec_pkg::HIGH_MAX) begin
                        rx_st_r <= RX_IDLE;
                        rx_err_r <= 1'b1;
                    end
                end
                RX_CHAR: begin
                    if (rx_tmr_r == rx_samp) begin
                        rx_tmr_r <= 16'h0000;
                        rx_bit_r <= 4'(rx_bit_r + 4'h1);
                        if (rx_bit_r == 4'h0) begin
                            if (rx_s2_r) begin
                                rx_st_r <= RX_IDLE;
                                rx_err_r <= 1'b1;
                            end
                        end else if (rx_bit_r != tag_codec_pkg::STOP_BIT_IDX)
                        begin
                            rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
                        end else if (rx_s2_r) begin
                            if (rx_cnt_r == tag_codec_pkg::MAX_BYTES) begin
                                rx_st_r <= RX_IDLE;
                                rx_err_r <= 1'b1;
                            end else begin
                                rx_data_r[{rx_cnt_r[2:0], 3'b000} +: 8] <=
                                    rx_sh_r;
                                rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
                                rx_st_r <= RX_GAP;
                            end
                        end else if (rx_sh_r == 8'h00) begin
                            // All-low character is the request end marker
                            rx_st_r <= RX_EOF;
                        end else begin
                            rx_st_r <= RX_IDLE;
                            rx_err_r <= 1'b1;
                        end
                    end
                end
                RX_GAP: begin
                    if (rx_fall) begin
                        rx_tmr_r <= 16'h0000;
                        rx_bit_r <= 4'h0;
                        rx_st_r <= RX_CHAR;
                    end else if (rx_tmr_r > tag_codec_pkg::GAP_MAX) begin
                        rx_st_r <= RX_IDLE;
                        rx_err_r <= 1'b1;
                    end
                end
                RX_EOF: begin
                    if (rx_rise) begin
                        rx_st_r <= RX_IDLE;
                        if (rx_cnt_r >= tag_codec_pkg::CRC_BYTES &&
                            rx_crc == tag_codec_pkg::CRC_RESIDUE) begin
                            rx_frame_r.valid <= 1'b1;
                            rx_frame_r.len <=
                                4'(rx_cnt_r - tag_codec_pkg::CRC_BYTES);
                            rx_frame_r.data <= rx_data_r;
                        end else begin
                            rx_err_r <= 1'b1;
                        end
                    end else if (rx_tmr_r > tag_codec_pkg::EOF_RISE_MAX) begin
                        rx_st_r <= RX_IDLE;
                        rx_err_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Quiet time since the last frame in either direction
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            guard_cnt_r <= 16'h0000;
        end else if (rx_busy || tx_st_r == TX_SOF || tx_st_r == TX_CHAR ||
            tx_st_r == TX_EOF) begin
            guard_cnt_r <= 16'h0000;
        end else if (guard_cnt_r < GUARD_LIMIT) begin
            guard_cnt_r <= 16'(guard_cnt_r + 16'h0001);
        end
    end

    // Free-running 847 kHz subcarrier
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            subc_cnt_r <= 8'h00;
            subc_r <= 1'b0;
        end else if (subc_flip) begin
            subc_cnt_r <= 8'h00;
            subc_r <= !subc_r;
        end else begin
            subc_cnt_r <= 8'(subc_cnt_r + 8'h01);
        end
    end

    assign subc_flip =
        (subc_cnt_r == 8'(tag_codec_pkg::SUBC_HALF_CYCLES - 8'h01));
    assign tx_ready = (tx_st_r == TX_IDLE);
    assign tx_busy = !tx_ready;
    assign tx_bit_end =
        (tx_tmr_r == 16'(tag_codec_pkg::BIT_CYCLES - 16'h0001));
    assign tx_crc_en = (tx_st_r == TX_CHAR) && tx_bit_end &&
        (tx_bit_r == tag_codec_pkg::STOP_BIT_IDX) && (tx_idx_r < tx_len_r);
    assign tx_on = (tx_st_r == TX_SYNC) || (tx_st_r == TX_SOF) ||
        (tx_st_r == TX_CHAR) || (tx_st_r == TX_EOF);

    crc16_unit u_tx_crc (
        .clk_sys(clk_sys),
        .srst(srst),
        .init(tx_req.valid && tx_ready),
        .en(tx_crc_en),
        .din(tx_byte),
        .crc_r(tx_crc)
    );

    // Byte and bit level being sent
    always_comb begin
        tx_byte = tx_data_r[{tx_idx_r[2:0], 3'b000} +: 8];
        if (tx_idx_r == tx_len_r) begin
            tx_byte = ~tx_crc[7:0];
        end else if (tx_idx_r > tx_len_r) begin
            tx_byte = ~tx_crc[15:8];
        end
        tx_lvl = 1'b1;
        unique case (tx_st_r)
            TX_SOF, TX_EOF: tx_lvl = (tx_bit_r >= MARK_ZERO_BITS);
            TX_CHAR: begin
                if (tx_bit_r == 4'h0) begin
                    tx_lvl = 1'b0;
                end else if (tx_bit_r == tag_codec_pkg::STOP_BIT_IDX) begin
                    tx_lvl = 1'b1;
                end else begin
                    tx_lvl = tx_byte[3'(tx_bit_r - 4'h1)];
                end
            end
            default: tx_lvl = 1'b1;
        endcase
    end

    // Answer builder
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_st_r <= TX_IDLE;
            tx_tmr_r <= 16'h0000;
            tx_bit_r <= 4'h0;
            tx_idx_r <= 4'h0;
            tx_len_r <= 4'h0;
            tx_data_r <= 64'h0;
            sync_cnt_r <= 10'h000;
        end else begin
            tx_tmr_r <= tx_bit_end ? 16'h0000 : 16'(tx_tmr_r + 16'h0001);
            unique case (tx_st_r)
                TX_IDLE: begin
                    if (tx_req.valid) begin
                        tx_data_r <= tx_req.data;
                        tx_len_r <= (tx_req.len > tag_codec_pkg::MAX_BYTES -
                            tag_codec_pkg::CRC_BYTES) ?
                            4'(tag_codec_pkg::MAX_BYTES -
                            tag_codec_pkg::CRC_BYTES) : tx_req.len;
                        tx_idx_r <= 4'h0;
                        tx_st_r <= TX_GUARD;
                    end
                end
                TX_GUARD: begin
                    sync_cnt_r <= 10'h000;
                    if (guard_cnt_r >= GUARD_LIMIT && subc_flip) begin
                        tx_st_r <= TX_SYNC;
                    end
                end
                TX_SYNC: begin
                    if (subc_flip) begin
                        sync_cnt_r <= 10'(sync_cnt_r + 10'h001);
                        if (sync_cnt_r ==
                            10'(tag_codec_pkg::SYNC_HALVES - 10'h001)) begin
                            tx_st_r <= TX_SOF;
                            tx_bit_r <= 4'h0;
                            tx_tmr_r <= 16'h0000;
                        end
                    end
                end
                TX_SOF: begin
                    if (tx_bit_end) begin
                        tx_bit_r <= 4'(tx_bit_r + 4'h1);
                        if (tx_bit_r == tag_codec_pkg::MARK_LAST_BIT) begin
                            tx_bit_r <= 4'h0;
                            tx_st_r <= TX_CHAR;
                        end
                    end
                end
                TX_CHAR: begin
                    if (tx_bit_end) begin
                        tx_bit_r <= 4'(tx_bit_r + 4'h1);
                        if (tx_bit_r == tag_codec_pkg::STOP_BIT_IDX) begin
                            tx_bit_r <= 4'h0;
                            tx_idx_r <= 4'(tx_idx_r + 4'h1);
                            if (tx_idx_r == 4'(tx_len_r + 4'h1)) begin
                                tx_st_r <= TX_EOF;
                            end
                        end
                    end
                end
                TX_EOF: begin
                    if (tx_bit_end) begin
                        tx_bit_r <= 4'(tx_bit_r + 4'h1);
                        if (tx_bit_r == tag_codec_pkg::MARK_LAST_BIT) begin
                            tx_bit_r <= 4'h0;
                            tx_st_r <= TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Logic one keeps the reference phase, logic zero inverts it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            load_mod_r <= 1'b0;
        end else begin
            load_mod_r <= tx_on && (subc_r ^ !tx_lvl);
        end
    end

    block_store u_store (
        .clk_sys(clk_sys),
        .srst(srst),
        .req(mem_req),
        .rsp_r(mem_rsp)
    );
endmodule // tag_frame_codec

// file: bench/tag_frame_codec_chk.sv
// Purpose: Port checker for the tag frame codec
// Assumes: Bound to every tag_frame_codec instance
// Notes: Guard limit follows the GUARD_CYCLES parameter
`timescale 1ns/1ns
module tag_frame_codec_chk #(
    parameter int unsigned GUARD_CYCLES = 200
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic rx_demod,
    input tag_codec_pkg::frame_t rx_frame_r,
    input wire logic rx_err_r,
    input wire logic rx_busy,
    input tag_codec_pkg::frame_t tx_req,
    input wire logic tx_ready,
    input wire logic tx_busy,
    input wire logic load_mod_r,
    input tag_codec_pkg::mem_req_t mem_req,
    input tag_codec_pkg::mem_rsp_t mem_rsp
);
    logic [15:0] quiet_r;
    // Unmodulated cycles since the last frame ended
    always_ff @(posedge clk_sys) begin
        if (srst || rx_busy || $fell(tx_busy)) begin
            quiet_r <= 16'h0;
        end else if (!load_mod_r && quiet_r != 16'hffff) begin
            quiet_r <= quiet_r + 16'h1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_read_answers: assert property (mem_req.valid && !mem_req.write
        |=> mem_rsp.valid) else $error("read got no response");
    a_no_stray_rsp: assert property (!(mem_req.valid && !mem_req.write)
        |=> !mem_rsp.valid) else $error("response without read");
    a_write_readback: assert property (mem_req.valid && mem_req.write
        && mem_req.permit ##1 mem_req.valid && !mem_req.write
        && mem_req.addr == $past(mem_req.addr)
        |=> mem_rsp.rdata == $past(mem_req.wdata, 2))
        else $error("written block not read back");
    a_frame_pulse: assert property (rx_frame_r.valid |=> !rx_frame_r.valid)
        else $error("frame valid longer than one cycle");
    a_err_alone: assert property (rx_err_r |=> !rx_err_r && !rx_frame_r.valid)
        else $error("error pulse not alone");
    a_frame_len: assert property (rx_frame_r.valid |->
        rx_frame_r.len <= 4'h6 && !rx_busy) else $error("bad frame length");
    a_rx_wakes: assert property ($fell(rx_demod) && !rx_busy
        |-> ##[2:4] rx_busy) else $error("parser missed falling edge");
    a_ready_busy: assert property (tx_ready && tx_req.valid
        |=> tx_busy && !load_mod_r) else $error("answer request not taken");
    a_guard_quiet: assert property ($rose(load_mod_r)
        |-> quiet_r >= GUARD_CYCLES - 2) else $error("modulation in guard");
    a_idle_silent: assert property (tx_ready && $past(tx_ready)
        && $past(tx_ready, 2) |-> !load_mod_r) else $error("idle modulation");
endmodule // tag_frame_codec_chk
bind tag_frame_codec tag_frame_codec_chk #(.GUARD_CYCLES(GUARD_CYCLES)) chk_i (
    .clk_sys(clk_sys), .srst(srst), .rx_demod(rx_demod),
    .rx_frame_r(rx_frame_r), .rx_err_r(rx_err_r), .rx_busy(rx_busy),
    .tx_req(tx_req), .tx_ready(tx_ready), .tx_busy(tx_busy),
    .load_mod_r(load_mod_r), .mem_req(mem_req), .mem_rsp(mem_rsp));

// file: bench/reader_model.sv
// Purpose: Reader side model driving the demodulated envelope
// Assumes: Caller enters send just after a clock edge
// Notes: Idle envelope is unmodulated, so it rests at one
`timescale 1ns/1ns
module reader_model (
    input wire logic clk_sys,
    output logic rx_demod
);
    localparam int BIT = int'(tag_codec_pkg::BIT_CYCLES);
    initial rx_demod = 1'b1;
    task automatic lvl(input logic v, input int cyc);
        rx_demod <= v;
        repeat (cyc) @(posedge clk_sys);
    endtask
    // Character bad_k gets a stop bit of zero and ends the frame early
    task automatic send(input logic [7:0] b[$], input int bad_k);
        @(posedge clk_sys);
        lvl(1'b0, 10 * BIT);
        lvl(1'b1, 2 * BIT + BIT / 2);
        foreach (b[k]) begin
            lvl(1'b0, BIT);
            for (int i = 0; i < 8; i++) begin
                lvl(b[k][i], BIT);
            end
            lvl(k != bad_k, BIT);
            if (k == bad_k) begin
                lvl(1'b1, 4 * BIT);
                return;
            end
        end
        lvl(1'b0, 10 * BIT);
        lvl(1'b1, 4 * BIT);
    endtask
endmodule // reader_model

// file: bench/tb.sv
// Purpose: Self-checking bench for the tag frame codec
// Assumes: Short guard parameter keeps the run brief
// Notes: Expected outcomes wait in a queue until the codec reports
`timescale 1ns/1ns
module tb;
    localparam int GUARD = 200;
    localparam int BIT = int'(tag_codec_pkg::BIT_CYCLES);
    localparam int HALF = int'(tag_codec_pkg::SUBC_HALF_CYCLES);
    localparam int SPAN = 256 * HALF + (12 + 10 * 3 + 12) * BIT;
    logic clk_sys, srst, rx_demod, rx_err_r, rx_busy;
    logic tx_ready, tx_busy, load_mod_r;
    tag_codec_pkg::frame_t rx_frame_r, tx_req, e_f;
    tag_codec_pkg::mem_req_t mem_req;
    tag_codec_pkg::mem_rsp_t mem_rsp;
    tag_codec_pkg::frame_t exp_q[$];
    int n_mismatch = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'hba02;
    logic [31:0] d;
    logic [5:0] a;
    tag_frame_codec #(.GUARD_CYCLES(GUARD)) tag_frame_codec_i (
        .clk_sys(clk_sys), .srst(srst), .rx_demod(rx_demod),
        .rx_frame_r(rx_frame_r), .rx_err_r(rx_err_r), .rx_busy(rx_busy),
        .tx_req(tx_req), .tx_ready(tx_ready), .tx_busy(tx_busy),
        .load_mod_r(load_mod_r), .mem_req(mem_req), .mem_rsp(mem_rsp));
    reader_model reader_model_i (.clk_sys(clk_sys), .rx_demod(rx_demod));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[k]) begin
            c ^= {8'h0, b[k]};
            for (int i = 0; i < 8; i++) begin
                c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
            end
        end
        return ~c;
    endfunction
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Each receive outcome is matched against the oldest prediction
    always @(negedge clk_sys) begin
        if (rx_frame_r.valid === 1'b1 || rx_err_r === 1'b1) begin
            e_f = exp_q.size() > 0 ? exp_q.pop_front() : '1;
            check("frame ok", 64'(rx_frame_r.valid), 64'(e_f.valid));
            if (e_f.valid === 1'b1) begin
                check("len", 64'(rx_frame_r.len), 64'(e_f.len));
                check("data", rx_frame_r.data & ((64'h1 << (8 * e_f.len)) - 1),
                      e_f.data);
            end
        end
    end
    task automatic request(input int n, input logic bad_crc, input int bad_k);
        logic [7:0] b[$];
        logic [15:0] c;
        tag_codec_pkg::frame_t f;
        f = '0;
        for (int i = 0; i < n; i++) begin
            b.push_back(8'(rnd()) | 8'h01);
            f.data[8*i +: 8] = b[i];
        end
        c = crc_of(b) ^ {15'h0, bad_crc};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        f.valid = !bad_crc && bad_k < 0;
        f.len = 4'(n);
        exp_q.push_back(f);
        reader_model_i.send(b, bad_k);
        repeat (8) @(posedge clk_sys);
        check("outcome seen", 64'(exp_q.size()), 64'h0);
        $display("request of %0d bytes done", n);
    endtask
    task automatic mem_op(input logic w, input logic p, input logic [31:0] v);
        mem_req <= '{1'b1, w, p, a, v};
        @(posedge clk_sys);
    endtask
    task automatic tx_check();
        int t;
        int w;
        int w0;
        logic ph;
        logic [63:0] v;
        logic [63:0] bits;
        logic [15:0] c;
        logic [7:0] q[$];
        v = 64'(rnd());
        q.push_back(v[7:0]);
        c = crc_of(q);
        bits = '0;
        w0 = 0;
        tx_req <= '{1'b1, 4'h1, v};
        @(posedge clk_sys);
        tx_req.valid <= 1'b0;
        for (t = 0; load_mod_r !== 1'b1 && t < 30000; t++) @(posedge clk_sys);
        check("guard", 64'(t >= GUARD - 20 && t <= GUARD + 2 * HALF), 1);
        for (w = 0; load_mod_r === 1'b1 && w < 300; w++) @(posedge clk_sys);
        check("half period", 64'(w), 64'(HALF));
        while (tx_ready !== 1'b1 && w < 2 * SPAN) begin
            // Reference phase locked to the first modulated high half
            ph = (w % (2 * HALF)) < HALF;
            if (w0 == 0 && load_mod_r !== ph) begin
                w0 = w;
            end
            if (w0 > 0 && (w - w0) % BIT == BIT / 2) begin
                bits[(w - w0) / BIT] = (load_mod_r === ph);
            end
            @(posedge clk_sys);
            w++;
        end
        check("answer span", 64'(w > SPAN - 160 && w < SPAN + 160), 1);
        check("answer bits", bits, {10'h0, 12'hc00, 1'b1, c[15:8], 2'b01,
              c[7:0], 2'b01, v[7:0], 1'b0, 12'hc00});
        $display("answer done");
    endtask
    initial begin
        srst = 1'b1;
        tx_req = '0;
        mem_req = '0;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(negedge clk_sys);
        check("reset", {rx_busy, tx_busy, load_mod_r, rx_err_r}, 0);
        @(posedge clk_sys);
        tx_check();
        for (int j = 0; j < 2; j++) begin
            a = j ? 6'h3f : 6'(rnd());
            d = rnd();
            @(posedge clk_sys);
            mem_op(1'b1, 1'b1, d);
            mem_op(1'b0, 1'b0, 32'h0);
            mem_req <= '0;
            @(negedge clk_sys);
            check("read back", 64'(mem_rsp), {32'h1, d});
            @(posedge clk_sys);
            mem_op(1'b1, 1'b0, ~d);
            mem_op(1'b0, 1'b0, 32'h0);
            mem_req <= '0;
            @(negedge clk_sys);
            check("refused write", 64'(mem_rsp), {32'h1, d});
        end
        $display("memory done");
        @(posedge clk_sys);
        request(2, 1'b0, -1);
        request(0, 1'b1, -1);
        request(1, 1'b0, 0);
        final_report();
    end
    initial begin
        repeat (400000) @(posedge clk_sys);
        n_mismatch++;
        final_report();
    end
endmodule // tb
